// File: core/cpc_clock_power.sv
// Operation
// - reset selects the slow clock for the cpu, select bit 0.
// - reset switches the fast oscillator off.
// - reset sets the regulator level field to 0, low-speed 1.1 V.
// - reset turns lcd supply off and sets its reference select to 1.
// - reset turns the supply voltage detector off.
// - reset turns heavy-load protection mode off.
// - sleep stops the fast oscillator completely.
// - sleep keeps slow oscillator running but gates divider and peripheral clocks.
// - only a key input interrupt factor wakes the device from sleep.
// - lcd supply switch-on runs a boost period of one 1 kHz cycle.
// - filter select code 00 bypasses the key noise rejector.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`include "cpc_params.svh"
`timescale 1ns/10ps
`default_nettype none
module cpc_clock_power #(
  parameter int SETTLE_CYCLES = (`CPC_OSC_SETTLE_US * 1000) / `CPC_CLK_NS,
  parameter int KEYS = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // axi4-lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // keys, 1 khz tick, other interrupt sources
  input wire logic [KEYS-1:0] key_inputs,
  input wire logic tick_1khz,
  input wire logic other_irq,
  // clock and power controls
  output logic cpu_clock_select,
  output logic fast_osc_enable,
  output logic [1:0] regulator_level_sel,
  output logic lcd_supply_on,
  output logic lcd_reference_sel,
  output logic voltage_detect_on,
  output logic heavy_load_mode,
  output logic fast_osc_run,
  output logic slow_osc_run,
  output logic periph_clk_en,
  output logic cpu_clk_en,
  output logic lcd_boost,
  output logic key_irq
);
  logic [7:0] ctrl_q;
  logic [KEYS-1:0] key_irq_select_q, key_irq_mask_q, key_flag_q;
  logic [1:0] key_filter_select_q;
  cpc_pkg::cpc_mode_t mode_q;
  logic boost_q, lcd_on_prev_q;
  logic [1:0] boost_ticks_q;
  logic [31:0] settle_q;
  logic osc_ready;
  logic [KEYS-1:0] key_q, filt_q, filt_prev_q, key_event;
  logic key_wake;
  logic aw_hold_q, w_hold_q, bvalid_q, rvalid_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q, rdata_q;
  logic [3:0] wstrb_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, rd_fire;
  logic [31:0] rd_word;
  logic rd_ok;

  // write channel: address and data are taken in either order
  assign s_axi_awready = !aw_hold_q && !bvalid_q;
  assign s_axi_wready = !w_hold_q && !bvalid_q;
  assign wr_fire = aw_hold_q && w_hold_q && !bvalid_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_hold_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_q <= 1'b1;
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_hold_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `CPC_RESP_OK;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q <= (awaddr_q == `CPC_CTRL_OFF || awaddr_q == `CPC_KEY_OFF || awaddr_q == `CPC_CMD_OFF ||
                  awaddr_q == `CPC_FLAG_OFF || awaddr_q == `CPC_STAT_OFF) ? `CPC_RESP_OK : `CPC_RESP_ERR;
    end else if (s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // control register; software owns the ordering of level, enable and select
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= 8'h00;
      ctrl_q[`CPC_REG_HI:`CPC_REG_LO] <= `CPC_REG_RST;
      ctrl_q[`CPC_LCD_REF_BIT] <= `CPC_LCD_REF_RST;
    end else if (wr_fire && awaddr_q == `CPC_CTRL_OFF && wstrb_q[0]) begin
      ctrl_q <= wdata_q[7:0];
    end
  end

  assign cpu_clock_select = ctrl_q[`CPC_CLK_SEL_BIT];
  assign fast_osc_enable = ctrl_q[`CPC_OSC_EN_BIT];
  assign regulator_level_sel = ctrl_q[`CPC_REG_HI:`CPC_REG_LO];
  assign lcd_supply_on = ctrl_q[`CPC_LCD_ON_BIT];
  assign lcd_reference_sel = ctrl_q[`CPC_LCD_REF_BIT];
  assign voltage_detect_on = ctrl_q[`CPC_SVD_BIT];
  assign heavy_load_mode = ctrl_q[`CPC_HLM_BIT];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_irq_select_q <= '0;
      key_irq_mask_q <= '0;
      key_filter_select_q <= `CPC_FILT_BYPASS;
    end else if (wr_fire && awaddr_q == `CPC_KEY_OFF) begin
      if (wstrb_q[0]) begin
        key_irq_select_q <= wdata_q[KEYS-1:0];
        key_irq_mask_q <= wdata_q[`CPC_MASK_LO +: KEYS];
      end
      if (wstrb_q[1]) begin
        key_filter_select_q <= wdata_q[`CPC_FILT_HI:`CPC_FILT_LO];
      end
    end
  end

  // key sampling and optional noise rejector
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_q <= '1;
      filt_prev_q <= '1;
    end else begin
      key_q <= key_inputs;
      filt_prev_q <= filt_q;
    end
  end

  for (genvar i = 0; i < KEYS; i++) begin : g_key
    logic [15:0] stable_q;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        stable_q <= 16'h0000;
        filt_q[i] <= 1'b1;
      end else if (key_filter_select_q == `CPC_FILT_BYPASS) begin
        stable_q <= 16'h0000;
        filt_q[i] <= key_inputs[i];
      end else if (key_q[i] == filt_q[i]) begin
        stable_q <= 16'h0000;
      end else if (stable_q >= (`CPC_FILT_BASE << key_filter_select_q)) begin
        filt_q[i] <= key_q[i];
        stable_q <= 16'h0000;
      end else begin
        stable_q <= stable_q + 16'h0001;
      end
    end
  end

  // a selected key falling low is an interrupt factor
  assign key_event = filt_prev_q & ~filt_q & key_irq_select_q;
  assign key_wake = |key_event;
  assign key_irq = |(key_flag_q & key_irq_mask_q);

  // factor flags clear on writing 1; a new factor in the same cycle wins
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      key_flag_q <= '0;
    end else if (wr_fire && awaddr_q == `CPC_FLAG_OFF && wstrb_q[0]) begin
      key_flag_q <= (key_flag_q & ~wdata_q[KEYS-1:0]) | key_event;
    end else begin
      key_flag_q <= key_flag_q | key_event;
    end
  end

  // cpu power mode
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= cpc_pkg::PM_RUN;
    end else begin
      case (mode_q)
        cpc_pkg::PM_RUN: begin
          if (wr_fire && awaddr_q == `CPC_CMD_OFF && wstrb_q[0] && wdata_q[0]) begin
            mode_q <= cpc_pkg::PM_SLEEP;
          end else if (wr_fire && awaddr_q == `CPC_CMD_OFF && wstrb_q[0] && wdata_q[1]) begin
            mode_q <= cpc_pkg::PM_HALT;
          end
        end
        cpc_pkg::PM_HALT: begin
          if (key_irq || other_irq) begin
            mode_q <= cpc_pkg::PM_RUN;
          end
        end
        cpc_pkg::PM_SLEEP: begin
          if (key_wake) begin
            mode_q <= cpc_pkg::PM_RUN;
          end
        end
        default: mode_q <= cpc_pkg::PM_RUN;
      endcase
    end
  end

  assign fast_osc_run = fast_osc_enable && mode_q != cpc_pkg::PM_SLEEP;
  assign slow_osc_run = 1'b1;
  assign periph_clk_en = mode_q != cpc_pkg::PM_SLEEP;
  assign cpu_clk_en = mode_q == cpc_pkg::PM_RUN;

  // settle counter only reports; selecting early is left to software
  always_ff @(posedge aclk) begin
    if (!aresetn || !fast_osc_run) begin
      settle_q <= 32'h0000_0000;
    end else if (!osc_ready) begin
      settle_q <= settle_q + 32'h0000_0001;
    end
  end
  assign osc_ready = settle_q >= 32'(SETTLE_CYCLES);

  // boost lasts until the second tick so at least one full 1 khz period passes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lcd_on_prev_q <= 1'b0;
      boost_q <= 1'b0;
      boost_ticks_q <= 2'h0;
    end else begin
      lcd_on_prev_q <= lcd_supply_on;
      if (!lcd_supply_on) begin
        boost_q <= 1'b0;
        boost_ticks_q <= 2'h0;
      end else if (!lcd_on_prev_q) begin
        boost_q <= 1'b1;
        boost_ticks_q <= 2'h0;
      end else if (boost_q && tick_1khz) begin
        boost_ticks_q <= boost_ticks_q + 2'h1;
        if (boost_ticks_q == 2'h1) begin
          boost_q <= 1'b0;
        end
      end
    end
  end
  assign lcd_boost = boost_q;

  // read channel, one cycle to answer
  assign s_axi_arready = !rvalid_q;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `CPC_CTRL_OFF: rd_word[7:0] = ctrl_q;
      `CPC_KEY_OFF: rd_word[`CPC_FILT_HI:0] = {key_filter_select_q, key_irq_mask_q, key_irq_select_q};
      `CPC_CMD_OFF: rd_word = 32'h0000_0000;
      `CPC_STAT_OFF: rd_word[3:0] = {boost_q, osc_ready, mode_q == cpc_pkg::PM_HALT, mode_q == cpc_pkg::PM_SLEEP};
      `CPC_FLAG_OFF: rd_word[KEYS-1:0] = key_flag_q;
      default: rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `CPC_RESP_OK;
    end else if (rd_fire) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_ok ? `CPC_RESP_OK : `CPC_RESP_ERR;
    end else if (s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence s_sleeping_woken;
    mode_q == cpc_pkg::PM_SLEEP ##0 key_wake;
  endsequence

  a_reset_clk_sel: assert property ($past(!aresetn) |-> !cpu_clock_select) else $error("cpu clock not slow after reset");
  a_reset_osc_off: assert property ($past(!aresetn) |-> !fast_osc_enable && !fast_osc_run) else $error("fast osc on after reset");
  a_reset_reg_level: assert property ($past(!aresetn) |-> regulator_level_sel == `CPC_REG_RST) else $error("regulator level wrong");
  a_reset_lcd_supply: assert property ($past(!aresetn) |-> !lcd_supply_on && lcd_reference_sel) else $error("lcd reset state wrong");
  a_reset_svd_off: assert property ($past(!aresetn) |-> !voltage_detect_on) else $error("detector on after reset");
  a_reset_heavy_off: assert property ($past(!aresetn) |-> !heavy_load_mode) else $error("heavy load on after reset");
  a_sleep_fast_stop: assert property (mode_q == cpc_pkg::PM_SLEEP |-> !fast_osc_run && !cpu_clk_en) else $error("fast osc runs in sleep");
  a_sleep_clock_gate: assert property (mode_q == cpc_pkg::PM_SLEEP |-> slow_osc_run && !periph_clk_en) else $error("sleep gating wrong");
  a_sleep_key_wake: assert property (s_sleeping_woken |=> mode_q == cpc_pkg::PM_RUN && cpu_clk_en) else $error("key did not wake");
  a_sleep_no_wake: assert property (mode_q == cpc_pkg::PM_SLEEP && !key_wake |=> mode_q == cpc_pkg::PM_SLEEP) else $error("woke without key");
  a_lcd_boost_start: assert property ($rose(lcd_supply_on) |=> lcd_boost ##1 (lcd_boost || !lcd_supply_on || tick_1khz)) else $error("boost missing");
  a_filter_bypass: assert property (key_filter_select_q == `CPC_FILT_BYPASS && $past(key_filter_select_q) == `CPC_FILT_BYPASS && key_irq_select_q[0] && $fell(key_inputs[0]) |-> ##[2:2] key_flag_q[0]) else $error("bypass path slow");
  a_halt_clocks: assert property (mode_q == cpc_pkg::PM_HALT |-> !cpu_clk_en && periph_clk_en && fast_osc_run == fast_osc_enable) else $error("halt gating wrong");
endmodule
`default_nettype wire

// File: core/cpc_params.svh
`ifndef CPC_PARAMS_SVH
`define CPC_PARAMS_SVH
// register byte offsets
`define CPC_CTRL_OFF 8'h00
`define CPC_KEY_OFF 8'h04
`define CPC_CMD_OFF 8'h08
`define CPC_STAT_OFF 8'h0C
`define CPC_FLAG_OFF 8'h10
// control field positions
`define CPC_CLK_SEL_BIT 0
`define CPC_OSC_EN_BIT 1
`define CPC_REG_LO 2
`define CPC_REG_HI 3
`define CPC_LCD_ON_BIT 4
`define CPC_LCD_REF_BIT 5
`define CPC_SVD_BIT 6
`define CPC_HLM_BIT 7
// key register field positions
`define CPC_MASK_LO 4
`define CPC_FILT_LO 8
`define CPC_FILT_HI 9
// reset values
`define CPC_REG_RST 2'h0
`define CPC_LCD_REF_RST 1'b1
`define CPC_FILT_BYPASS 2'h0
// settle time of the fast oscillator, in us, and clock period in ns
`define CPC_OSC_SETTLE_US 5000
`define CPC_CLK_NS 10
`define CPC_FILT_BASE 16'h0010
`define CPC_RESP_OK 2'h0
`define CPC_RESP_ERR 2'h2
`endif

// File: core/cpc_pkg.sv
package cpc_pkg;
  typedef enum logic [1:0] {
    PM_RUN,
    PM_HALT,
    PM_SLEEP
  } cpc_mode_t;
endpackage

// File: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [3:0] keys = 4'hF;
  logic tick = 1'b0;
  logic oirq = 1'b0;
  wire logic awready, wready, bvalid, arready, rvalid;
  wire logic [1:0] bresp, rresp, rlev;
  wire logic [31:0] rdata;
  wire logic csel, fen, lcd_on, lref, svd, hlm, frun, srun, pclk, cclk, boost, kirq;
  int n_errors = 0;
  int tests_run = 0;
  int cyc = 0;
  int ctrl_m = 0;
  logic [31:0] lfsr = 32'h8C3D9BF9;

  cpc_clock_power #(.SETTLE_CYCLES(20), .KEYS(4)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .key_inputs(keys), .tick_1khz(tick), .other_irq(oirq),
    .cpu_clock_select(csel), .fast_osc_enable(fen), .regulator_level_sel(rlev),
    .lcd_supply_on(lcd_on), .lcd_reference_sel(lref), .voltage_detect_on(svd),
    .heavy_load_mode(hlm), .fast_osc_run(frun), .slow_osc_run(srun),
    .periph_clk_en(pclk), .cpu_clk_en(cclk), .lcd_boost(boost), .key_irq(kirq)
  );

  always #5 aclk = ~aclk;

  task automatic conclude;
    if (n_errors == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // hang guard, well above the few hundred cycles the sequence needs
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  function automatic logic [31:0] lfsr_next(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction

  task automatic step(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // entered one edge early so a back-to-back call never re-drives bready in one step
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er});
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, er});
  endtask

  // control write through the model, then both the level outputs and the readback
  task automatic wc(input logic [7:0] d);
    wr(8'h00, {24'h0, d}, 2'h0);
    ctrl_m = d;
    chk({24'h0, hlm, svd, lref, lcd_on, rlev, fen, csel}, ctrl_m[31:0]);
    rd(8'h00, ctrl_m[31:0], 2'h0);
  endtask

  task automatic clocks(input logic [3:0] exp);
    chk({28'h0, frun, srun, pclk, cclk}, {28'h0, exp});
  endtask

  task automatic pulse_tick;
    tick <= 1'b1;
    @(posedge aclk);
    tick <= 1'b0;
  endtask

  initial begin
    step(4);
    aresetn <= 1'b1;
    step(1);
    chk({24'h0, hlm, svd, lref, lcd_on, rlev, fen, csel}, 32'h20);
    rd(8'h00, 32'h20, 2'h0);
    clocks(4'h7);
    // random control patterns keep the cpu on the slow clock with the fast oscillator off
    repeat (4) begin
      lfsr = lfsr_next(lfsr);
      wc(lfsr[7:0] & 8'hFC);
    end
    wc(8'h20);
    wr(8'h14, 32'h5A, 2'h2);
    rd(8'h14, 32'h0, 2'h2);
    // switch to the fast clock and back in the documented order
    wc(8'h24);
    step(10);
    wc(8'h26);
    rd(8'h0C, 32'h0, 2'h0);
    step(26);
    rd(8'h0C, 32'h4, 2'h0);
    wc(8'h27);
    wc(8'h26);
    wc(8'h24);
    wc(8'h20);
    // lcd boost lasts until the second tick
    wc(8'h30);
    step(2);
    chk({31'h0, boost}, 32'h1);
    pulse_tick();
    step(2);
    chk({31'h0, boost}, 32'h1);
    pulse_tick();
    step(2);
    chk({31'h0, boost}, 32'h0);
    // sleep with key 0 selected and masked in, filter bypassed
    wc(8'h24);
    step(10);
    wc(8'h26);
    wr(8'h04, 32'h011, 2'h0);
    wr(8'h08, 32'h1, 2'h0);
    step(1);
    clocks(4'h4);
    oirq <= 1'b1;
    keys <= 4'hD;
    step(4);
    oirq <= 1'b0;
    clocks(4'h4);
    keys <= 4'hC;
    step(4);
    clocks(4'hF);
    chk({31'h0, kirq}, 32'h1);
    rd(8'h10, 32'h1, 2'h0);
    keys <= 4'hF;
    wr(8'h10, 32'h1, 2'h0);
    step(1);
    chk({31'h0, kirq}, 32'h0);
    // halt only stops the cpu clock
    wr(8'h08, 32'h2, 2'h0);
    step(1);
    clocks(4'hE);
    oirq <= 1'b1;
    step(3);
    oirq <= 1'b0;
    clocks(4'hF);
    // filtered key: a fall must outlast the rejector window before it counts
    wr(8'h04, 32'h111, 2'h0);
    keys <= 4'hE;
    rd(8'h10, 32'h0, 2'h0);
    step(40);
    rd(8'h10, 32'h1, 2'h0);
    keys <= 4'hF;
    // mid-run reset must bring every control back to its reset state
    wc(8'hDC);
    aresetn <= 1'b0;
    step(2);
    aresetn <= 1'b1;
    step(1);
    chk({24'h0, hlm, svd, lref, lcd_on, rlev, fen, csel}, 32'h20);
    clocks(4'h7);
    rd(8'h10, 32'h0, 2'h0);
    conclude();
  end
endmodule
`default_nettype wire
